// *** core/dsom_top.sv ***
/*
 Drive status output mapper: maps drive conditions onto digital
 output channels by function code, with a Wishbone register file and
 a maskable interrupt. Assumes all drive inputs come from logic on mclk.
*/
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "dsom_regs.svh"
module dsom_top #(
   parameter int NCH = 4,
   parameter int SW = 16
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o,
   input wire logic drv_ready,
   input wire logic drv_fault,
   input wire logic drv_warn,
   input wire logic pos_done,
   input wire logic pos_near,
   input wire logic torque_limited,
   input wire logic speed_limited,
   input wire logic brake_operate,
   input wire dsom_pkg::dsom_mode_t ctrl_mode,
   input wire logic signed [SW-1:0] motor_speed,
   input wire logic signed [SW-1:0] speed_cmd,
   input wire logic signed [SW-1:0] speed_filt,
   input wire logic signed [SW-1:0] torque_cmd,
   output logic [NCH-1:0] do_out
);
   localparam logic signed [SW-1:0] ZERO = '0;

   logic [31:0] func_r, func_nxt;
   logic [SW-1:0] rot_thr_r, rot_thr_nxt;
   logic [SW-1:0] match_thr_r, match_thr_nxt;
   logic [SW-1:0] near_thr_r, near_thr_nxt;
   logic [SW-1:0] torq_thr_r, torq_thr_nxt;
   logic [SW-1:0] zero_thr_r, zero_thr_nxt;
   logic [2:0] mask_r, mask_nxt;
   logic [2:0] stat_r, stat_nxt;
   logic [2:0] prev_r, prev_nxt;
   logic ack_r, ack_nxt;
   logic [31:0] dat_r, dat_nxt;
   logic irq_r, irq_nxt;
   logic wr_en;
   logic [31:0] wmask;
   logic [2:0] evt;
   logic rot_gt, zero_lt, match_lt, near_lt, torq_gt;
   logic [`DSOM_FN_COUNT-1:0] cond;

   dsom_cmp #(.W(SW)) u_rot (.a(motor_speed), .b(ZERO),
      .thr(rot_thr_r), .lt(), .gt(rot_gt));
   dsom_cmp #(.W(SW)) u_zero (.a(motor_speed), .b(ZERO),
      .thr(zero_thr_r), .lt(zero_lt), .gt());
   dsom_cmp #(.W(SW)) u_match (.a(motor_speed), .b(speed_cmd),
      .thr(match_thr_r), .lt(match_lt), .gt());
   dsom_cmp #(.W(SW)) u_near (.a(speed_filt), .b(ZERO),
      .thr(near_thr_r), .lt(near_lt), .gt());
   dsom_cmp #(.W(SW)) u_torq (.a(torque_cmd), .b(ZERO),
      .thr(torq_thr_r), .lt(), .gt(torq_gt));

   // Index 0 is the unused code, held low
   always_comb begin
      cond = '0;
      cond[1] = drv_ready;
      cond[2] = drv_fault;
      cond[3] = drv_warn;
      cond[4] = rot_gt;
      cond[5] = zero_lt;
      cond[6] = pos_done;
      cond[7] = pos_near;
      cond[8] = match_lt && ctrl_mode == dsom_pkg::DSOM_MODE_SPEED;
      cond[9] = near_lt;
      cond[10] = !torq_gt;
      cond[11] = torque_limited;
      cond[12] = speed_limited
         && ctrl_mode == dsom_pkg::DSOM_MODE_TORQUE;
      cond[13] = brake_operate;
   end

   // Byte per channel limits the block to four channels
   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++) begin : g_ch
         dsom_chan u_ch (
            .mclk(mclk),
            .srst(srst),
            .code(func_r[gi*8 +: 6]),
            .cond(cond),
            .out(do_out[gi])
         );
      end
   endgenerate

   always_comb begin
      wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;
      wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
         {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   end

   // Configuration registers
   always_comb begin
      func_nxt = func_r;
      rot_thr_nxt = rot_thr_r;
      match_thr_nxt = match_thr_r;
      near_thr_nxt = near_thr_r;
      torq_thr_nxt = torq_thr_r;
      zero_thr_nxt = zero_thr_r;
      mask_nxt = mask_r;
      if (wr_en) begin
         case (wb_adr_i)
            `DSOM_OFF_FUNC: begin
               func_nxt = (func_r & ~wmask) | (wb_dat_i & wmask);
            end
            `DSOM_OFF_ROT_THR: begin
               rot_thr_nxt = SW'((32'(rot_thr_r) & ~wmask)
                  | (wb_dat_i & wmask));
            end
            `DSOM_OFF_MATCH_THR: begin
               match_thr_nxt = SW'((32'(match_thr_r) & ~wmask)
                  | (wb_dat_i & wmask));
            end
            `DSOM_OFF_NEAR_THR: begin
               near_thr_nxt = SW'((32'(near_thr_r) & ~wmask)
                  | (wb_dat_i & wmask));
            end
            `DSOM_OFF_TORQ_THR: begin
               torq_thr_nxt = SW'((32'(torq_thr_r) & ~wmask)
                  | (wb_dat_i & wmask));
            end
            `DSOM_OFF_ZERO_THR: begin
               zero_thr_nxt = SW'((32'(zero_thr_r) & ~wmask)
                  | (wb_dat_i & wmask));
            end
            `DSOM_OFF_IRQ_MASK: begin
               if (wb_sel_i[0]) begin
                  mask_nxt = wb_dat_i[2:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         func_r <= `DSOM_RST_FUNC;
         rot_thr_r <= `DSOM_RST_ROT_THR;
         match_thr_r <= `DSOM_RST_MATCH_THR;
         near_thr_r <= `DSOM_RST_NEAR_THR;
         torq_thr_r <= `DSOM_RST_TORQ_THR;
         zero_thr_r <= `DSOM_RST_ZERO_THR;
         mask_r <= `DSOM_RST_MASK;
      end else begin
         func_r <= func_nxt;
         rot_thr_r <= rot_thr_nxt;
         match_thr_r <= match_thr_nxt;
         near_thr_r <= near_thr_nxt;
         torq_thr_r <= torq_thr_nxt;
         zero_thr_r <= zero_thr_nxt;
         mask_r <= mask_nxt;
      end
   end

   // Sticky events; a new event beats a same-cycle clear
   always_comb begin
      prev_nxt = {brake_operate, drv_warn, drv_fault};
      evt = '0;
      evt[`DSOM_IRQ_FAULT] = drv_fault && !prev_r[0];
      evt[`DSOM_IRQ_WARN] = drv_warn && !prev_r[1];
      evt[`DSOM_IRQ_BRAKE] = brake_operate != prev_r[2];
      stat_nxt = stat_r;
      if (wr_en && wb_adr_i == `DSOM_OFF_IRQ_STAT && wb_sel_i[0]) begin
         stat_nxt = stat_r & ~wb_dat_i[2:0];
      end
      stat_nxt = stat_nxt | evt;
      irq_nxt = |(stat_nxt & mask_nxt);
   end

   // Bus answer one cycle after the request; unmapped reads give zero
   always_comb begin
      ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
      dat_nxt = '0;
      case (wb_adr_i)
         `DSOM_OFF_FUNC: dat_nxt = func_r;
         `DSOM_OFF_ROT_THR: dat_nxt = 32'(rot_thr_r);
         `DSOM_OFF_MATCH_THR: dat_nxt = 32'(match_thr_r);
         `DSOM_OFF_NEAR_THR: dat_nxt = 32'(near_thr_r);
         `DSOM_OFF_TORQ_THR: dat_nxt = 32'(torq_thr_r);
         `DSOM_OFF_ZERO_THR: dat_nxt = 32'(zero_thr_r);
         `DSOM_OFF_STATE: dat_nxt = {4'h0, 4'(do_out), 6'h00,
            ctrl_mode, 2'h0, cond};
         `DSOM_OFF_IRQ_STAT: dat_nxt = {29'h0000_0000, stat_r};
         `DSOM_OFF_IRQ_MASK: dat_nxt = {29'h0000_0000, mask_r};
         default: dat_nxt = '0;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         prev_r <= 3'h0;
         stat_r <= 3'h0;
         irq_r <= 1'b0;
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end else begin
         prev_r <= prev_nxt;
         stat_r <= stat_nxt;
         irq_r <= irq_nxt;
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
   assign irq_o = irq_r;

   default clocking dsom_cb @(posedge mclk);
   endclocking
   default disable iff (srst);

   logic [5:0] code0;
   assign code0 = func_r[5:0];

   AST_READY: assert property (
      ($past(code0) == `DSOM_FN_READY && !$past(srst))
      |-> do_out[0] == $past(drv_ready))
      else $error("ready channel wrong");
   AST_FAULT: assert property (
      (code0 == `DSOM_FN_FAULT && drv_fault) ##1 code0 == `DSOM_FN_FAULT
      |-> do_out[0])
      else $error("fault not shown");
   AST_WARN: assert property (
      (code0 == `DSOM_FN_WARN && drv_warn) |=> do_out[0])
      else $error("warning not shown");
   AST_ROTATE: assert property (
      (code0 == `DSOM_FN_ROTATE && motor_speed == ZERO) |=> !do_out[0])
      else $error("rotation shown at standstill");
   AST_ZERO: assert property (
      (code0 == `DSOM_FN_ZERO && motor_speed == ZERO
      && zero_thr_r != '0) |=> do_out[0])
      else $error("zero speed not shown");
   AST_PDONE: assert property (
      (code0 == `DSOM_FN_PDONE) |=> do_out[0] == $past(pos_done))
      else $error("position done wrong");
   AST_PNEAR: assert property (
      (code0 == `DSOM_FN_PNEAR) |=> do_out[0] == $past(pos_near))
      else $error("position near wrong");
   AST_VNEAR: assert property (
      (code0 == `DSOM_FN_VNEAR && speed_filt == ZERO
      && near_thr_r != '0) |=> do_out[0])
      else $error("speed approach not shown");
   AST_TLIMIT: assert property (
      (code0 == `DSOM_FN_TLIMIT) |=> do_out[0] == $past(torque_limited))
      else $error("torque limit wrong");
   AST_VMATCH: assert property (
      (code0 == `DSOM_FN_VMATCH
      && ctrl_mode != dsom_pkg::DSOM_MODE_SPEED) |=> !do_out[0])
      else $error("speed match outside speed mode");
   AST_TREACH: assert property (
      (code0 == `DSOM_FN_TREACH && torque_cmd == ZERO) |=> do_out[0])
      else $error("torque arrival missing");
   AST_VLIMIT: assert property (
      (code0 == `DSOM_FN_VLIMIT && speed_limited
      && ctrl_mode == dsom_pkg::DSOM_MODE_TORQUE) |=> do_out[0])
      else $error("speed limit not shown");
   AST_BRAKE: assert property (
      (code0 == `DSOM_FN_BRAKE) ##1 (code0 == `DSOM_FN_BRAKE)[*2]
      |-> do_out[0] == $past(brake_operate))
      else $error("brake output wrong");
   AST_IRQ: assert property (
      (stat_r & mask_r) != 3'h0 |=> irq_r || $past(wr_en))
      else $error("interrupt dropped");
   AST_ACK: assert property (
      wb_cyc_i && wb_stb_i && !ack_r |=> ack_r ##1 !ack_r)
      else $error("bus answer timing wrong");
   AST_STAT_SET: assert property (
      drv_fault && !prev_r[0] |=> stat_r[`DSOM_IRQ_FAULT])
      else $error("fault event lost");

   CVR_FAULT: cover property (code0 == `DSOM_FN_FAULT ##1 do_out[0]);
   CVR_BRAKE: cover property ($rose(do_out[0]) && code0 == `DSOM_FN_BRAKE);
   CVR_IRQ: cover property ($rose(irq_r));
   CVR_WRITE: cover property (wr_en && wb_adr_i == `DSOM_OFF_FUNC);
endmodule // dsom_top

// *** shared/dsom_regs.svh ***
/*
 Register offsets, reset values and output function codes of the
 drive status output mapper. Assumes byte addressing on a 32-bit bus.
*/
`ifndef DSOM_REGS_SVH
`define DSOM_REGS_SVH

`define DSOM_OFF_FUNC 8'h00
`define DSOM_OFF_ROT_THR 8'h04
`define DSOM_OFF_MATCH_THR 8'h08
`define DSOM_OFF_NEAR_THR 8'h0C
`define DSOM_OFF_TORQ_THR 8'h10
`define DSOM_OFF_ZERO_THR 8'h14
`define DSOM_OFF_STATE 8'h18
`define DSOM_OFF_IRQ_STAT 8'h1C
`define DSOM_OFF_IRQ_MASK 8'h20

`define DSOM_RST_FUNC 32'h1C1C_1C1C
`define DSOM_RST_ROT_THR 16'h0014
`define DSOM_RST_MATCH_THR 16'h000A
`define DSOM_RST_NEAR_THR 16'h0064
`define DSOM_RST_TORQ_THR 16'h0064
`define DSOM_RST_ZERO_THR 16'h000A
`define DSOM_RST_MASK 3'h0

`define DSOM_IRQ_FAULT 0
`define DSOM_IRQ_WARN 1
`define DSOM_IRQ_BRAKE 2

`define DSOM_FN_OFF 6'h1C
`define DSOM_FN_READY 6'h1D
`define DSOM_FN_FAULT 6'h1E
`define DSOM_FN_WARN 6'h1F
`define DSOM_FN_ROTATE 6'h20
`define DSOM_FN_ZERO 6'h21
`define DSOM_FN_PDONE 6'h22
`define DSOM_FN_PNEAR 6'h23
`define DSOM_FN_VMATCH 6'h24
`define DSOM_FN_VNEAR 6'h25
`define DSOM_FN_TREACH 6'h26
`define DSOM_FN_TLIMIT 6'h27
`define DSOM_FN_VLIMIT 6'h28
`define DSOM_FN_BRAKE 6'h29
`define DSOM_FN_COUNT 14

`endif

// *** shared/dsom_pkg.sv ***
/*
 Types of the drive status output mapper.
 Assumes the drive core reports its control mode with this encoding.
*/
package dsom_pkg;
   typedef enum logic [1:0] {
      DSOM_MODE_POS = 2'h0,
      DSOM_MODE_SPEED = 2'h1,
      DSOM_MODE_TORQUE = 2'h2,
      DSOM_MODE_MIX = 2'h3
   } dsom_mode_t;
endpackage

// *** core/dsom_cmp.sv ***
/*
 Magnitude compare of a signed difference against a threshold.
 Assumes both operands are on the same clock; purely combinational.
*/
`timescale 1ns/1ps
module dsom_cmp #(
   parameter int W = 16
) (
   input wire logic signed [W-1:0] a,
   input wire logic signed [W-1:0] b,
   input wire logic [W-1:0] thr,
   output logic lt,
   output logic gt
);
   logic signed [W:0] diff;
   logic [W:0] mag;

   // One extra bit so the difference of two extremes cannot wrap
   always_comb begin
      diff = {a[W-1], a} - {b[W-1], b};
      mag = diff[W] ? $unsigned(-diff) : $unsigned(diff);
      lt = mag < {1'b0, thr};
      gt = mag > {1'b0, thr};
   end
endmodule // dsom_cmp

// *** core/dsom_chan.sv ***
/*
 One digital output channel: selects a condition by function code
 and registers it. Assumes conditions are synchronous to mclk.
*/
`timescale 1ns/1ps
`include "dsom_regs.svh"
module dsom_chan (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [5:0] code,
   input wire logic [`DSOM_FN_COUNT-1:0] cond,
   output logic out
);
   logic out_r;
   logic out_nxt;
   logic [5:0] idx;

   always_comb begin
      idx = code - `DSOM_FN_OFF;
      out_nxt = 1'b0;
      if (code > `DSOM_FN_OFF && code <= `DSOM_FN_BRAKE) begin
         out_nxt = cond[idx[3:0]];
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         out_r <= 1'b0;
      end else begin
         out_r <= out_nxt;
      end
   end

   assign out = out_r;

   AST_UNUSED_LOW: assert property (@(posedge mclk) disable iff (srst)
      (code < `DSOM_FN_READY || code > `DSOM_FN_BRAKE) |=> !out_r)
      else $error("unassigned code drove channel");
endmodule // dsom_chan

// *** tb/dsom_ctrl_model.sv ***
/*
 Controller-side reader of the channel outputs: latches what the
 drive shows. Assumes do_out is a registered level on mclk.
*/
`timescale 1ns/1ps
module dsom_ctrl_model #(
   parameter int NCH = 4
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [NCH-1:0] do_out,
   output logic [NCH-1:0] seen
);
   // One cycle behind, as a real input stage would see it
   always_ff @(posedge mclk) begin
      if (srst) begin
         seen <= '0;
      end else begin
         seen <= do_out;
      end
   end
endmodule // dsom_ctrl_model

// *** tb/dsom_top_bench.sv ***
/*
 Testbench of the status output mapper: Wishbone tasks, code table
 sweep, byte lanes, interrupt. Assumes one 10 MHz clock.
*/
`timescale 1ns/1ps
`include "dsom_regs.svh"
module dsom_top_bench;
   logic mclk = 0, srst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   logic [7:0] wb_adr_i = '0;
   logic [3:0] wb_sel_i = '0;
   logic [31:0] wb_dat_i = '0, wb_dat_o, q;
   logic wb_ack_o, irq_o, drv_ready = 0, drv_fault = 0, drv_warn = 0;
   logic pos_done = 0, pos_near = 0, torque_limited = 0;
   logic speed_limited = 0, brake_operate = 0;
   dsom_pkg::dsom_mode_t ctrl_mode = dsom_pkg::DSOM_MODE_POS;
   logic signed [15:0] motor_speed = '0, speed_cmd = '0;
   logic signed [15:0] speed_filt = '0, torque_cmd = '0;
   logic [3:0] do_out, seen;
   int error_cnt = 0, comparisons = 0;
   always #50 mclk = ~mclk;
   dsom_top #(.NCH(4), .SW(16)) u_dut (.mclk(mclk), .srst(srst),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
      .drv_ready(drv_ready), .drv_fault(drv_fault), .drv_warn(drv_warn),
      .pos_done(pos_done), .pos_near(pos_near),
      .torque_limited(torque_limited), .speed_limited(speed_limited),
      .brake_operate(brake_operate), .ctrl_mode(ctrl_mode),
      .motor_speed(motor_speed), .speed_cmd(speed_cmd),
      .speed_filt(speed_filt), .torque_cmd(torque_cmd), .do_out(do_out));
   dsom_ctrl_model #(.NCH(4)) u_ctrl (.mclk(mclk), .srst(srst),
      .do_out(do_out), .seen(seen));
   task automatic stop_test;
      $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp,
         input string msg);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h exp %h", $time, msg,
            got, exp);
      end
   endtask
   // One classic cycle; ack and read data taken at the same rising edge
   task automatic wb(input logic we, input logic [7:0] a,
         input logic [3:0] s, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= d;
      do begin
         @(posedge mclk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
      if (wb_ack_o !== 1'b1) begin
         error_cnt++;
         $display("wrong value at %0t: no ack", $time);
         stop_test();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 4'hF, 32'h0000_0000);
      check(q, exp, "register read");
   endtask
   // Makes condition i true or false, one assignment per signal
   task automatic drive(input int i, input logic v,
         input dsom_pkg::dsom_mode_t m);
      @(posedge mclk);
      drv_ready <= i == 1 && v;
      drv_fault <= i == 2 && v;
      drv_warn <= i == 3 && v;
      motor_speed <= i == 4 ? (v ? 16'hFFE2 : 16'h0005) :
         i == 5 ? (v ? 16'hFFFD : 16'h0032) : 16'h0064;
      pos_done <= i == 6 && v;
      pos_near <= i == 7 && v;
      speed_cmd <= v ? 16'h005F : 16'h0096;
      speed_filt <= v ? 16'hFFCE : 16'h00C8;
      torque_cmd <= v ? 16'hFF9C : 16'h0065;
      torque_limited <= i == 11 && v;
      speed_limited <= i == 12 && v;
      brake_operate <= i == 13 && v;
      ctrl_mode <= m;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
   endtask
   initial begin
      repeat (2) @(posedge mclk);
      srst <= 0;
      rd(`DSOM_OFF_FUNC, `DSOM_RST_FUNC);
      rd(`DSOM_OFF_ROT_THR, {16'h0000, `DSOM_RST_ROT_THR});
      rd(`DSOM_OFF_MATCH_THR, {16'h0000, `DSOM_RST_MATCH_THR});
      rd(`DSOM_OFF_NEAR_THR, {16'h0000, `DSOM_RST_NEAR_THR});
      rd(`DSOM_OFF_TORQ_THR, {16'h0000, `DSOM_RST_TORQ_THR});
      rd(`DSOM_OFF_ZERO_THR, {16'h0000, `DSOM_RST_ZERO_THR});
      wb(1'b1, 8'h40, 4'hF, 32'hFFFF_FFFF);
      rd(8'h40, 32'h0000_0000);
      rd(`DSOM_OFF_IRQ_MASK, 32'h0000_0000);
      $display("test reset values done");
      // Codes 28..41 on channel 0, others left unused
      for (int i = 0; i < 14; i++) begin
         wb(1'b1, `DSOM_OFF_FUNC, 4'hF, {24'h1C_1C1C, 8'(28 + i)});
         for (int v = 0; v < 2; v++) begin
            drive(i, v[0], i == 12 ? dsom_pkg::DSOM_MODE_TORQUE :
               dsom_pkg::DSOM_MODE_SPEED);
            check(32'(do_out), 32'(i != 0 && v == 1), "code");
         end
         if (i == 8 || i == 12) begin
            drive(i, 1'b1, i == 8 ? dsom_pkg::DSOM_MODE_TORQUE :
               dsom_pkg::DSOM_MODE_SPEED);
            check(32'(do_out), 32'h0000_0000, "mode");
         end
      end
      $display("test code table done");
      // Byte lane 3 only: channel 3 to brake, channel 0 keeps brake
      wb(1'b1, `DSOM_OFF_FUNC, 4'h8, 32'h2900_0000);
      rd(`DSOM_OFF_FUNC, 32'h291C_1C29);
      drive(13, 1'b1, dsom_pkg::DSOM_MODE_POS);
      check(32'(do_out), 32'h0000_0009, "brake");
      check(32'(seen), 32'h0000_0009, "reader");
      // Brake, rotation, approach and torque arrival true; position mode
      rd(`DSOM_OFF_STATE, 32'h0900_2610);
      drive(0, 1'b0, dsom_pkg::DSOM_MODE_POS);
      $display("test byte lanes done");
      wb(1'b1, `DSOM_OFF_IRQ_STAT, 4'h1, 32'h0000_0007);
      wb(1'b1, `DSOM_OFF_IRQ_MASK, 4'h1, 32'h0000_0001);
      @(negedge mclk);
      check(32'(irq_o), 32'h0000_0000, "irq idle");
      drive(2, 1'b1, dsom_pkg::DSOM_MODE_POS);
      check(32'(irq_o), 32'h0000_0001, "irq fault");
      rd(`DSOM_OFF_IRQ_STAT, 32'h0000_0001);
      drive(3, 1'b1, dsom_pkg::DSOM_MODE_POS);
      wb(1'b1, `DSOM_OFF_IRQ_STAT, 4'h1, 32'h0000_0001);
      @(negedge mclk);
      check(32'(irq_o), 32'h0000_0000, "irq masked");
      rd(`DSOM_OFF_IRQ_STAT, 32'h0000_0002);
      $display("test interrupt done");
      stop_test();
   end
   initial begin
      repeat (20000) @(posedge mclk);
      error_cnt++;
      stop_test();
   end
endmodule // dsom_top_bench
